// file: rtl/dpbr_pkg.sv
package dpbr_pkg;

  // array geometry of one 36 Kb block
  localparam int MEM_WORDS = 512;
  localparam int WORD_W    = 72;
  localparam int LANES     = 8;
  localparam int LANE_W    = 9;
  localparam int BYTE_W    = 8;
  localparam int DATA_W    = 64;
  localparam int PAR_W     = 8;
  localparam int ADDR_W    = 16;
  localparam int WORD_AW   = 9;
  localparam int CODE_W    = 8;
  localparam int WCODE_W   = 3;

  // port width codes
  localparam logic [WCODE_W-1:0] W_X1  = 3'h0;
  localparam logic [WCODE_W-1:0] W_X9  = 3'h1;
  localparam logic [WCODE_W-1:0] W_X18 = 3'h2;
  localparam logic [WCODE_W-1:0] W_X36 = 3'h3;
  localparam logic [WCODE_W-1:0] W_X72 = 3'h4;

  // byte enable sets
  localparam logic [PAR_W-1:0] FULL_BE = 8'h0f;
  localparam logic [PAR_W-1:0] ALL_BE  = 8'hff;

  // reset and set/reset values of the output stages
  localparam logic [WORD_W-1:0] SRVAL_RST = 72'h0;

  // memory operating mode
  typedef enum logic [2:0] {
    MODE_FULL    = 3'b001,
    MODE_SIMPLE  = 3'b010,
    MODE_CASCADE = 3'b100
  } dpbr_mode_t;

  // output behaviour on a write
  typedef enum logic [2:0] {
    WM_WRITE_FIRST = 3'b001,
    WM_READ_FIRST  = 3'b010,
    WM_NO_CHANGE   = 3'b100
  } dpbr_wmode_t;

endpackage : dpbr_pkg

// file: rtl/dpbr_bank.sv
`timescale 1ns/1ns
module dpbr_bank #(
  parameter int DEPTH = dpbr_pkg::MEM_WORDS,
  parameter int WIDTH = dpbr_pkg::WORD_W
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     power_on,
  input  wire logic [$clog2(DEPTH)-1:0] a_word,
  input  wire logic [WIDTH-1:0]         a_mask,
  input  wire logic [WIDTH-1:0]         a_data,
  input  wire logic [$clog2(DEPTH)-1:0] b_word,
  input  wire logic [WIDTH-1:0]         b_mask,
  input  wire logic [WIDTH-1:0]         b_data,
  input  wire logic [$clog2(DEPTH)-1:0] rb_word,
  output logic      [WIDTH-1:0]         a_q,
  output logic      [WIDTH-1:0]         b_q,
  output logic      [WIDTH-1:0]         rb_q
);
  import dpbr_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } dpbr_bank_state_t;

  dpbr_bank_state_t st;
  dpbr_bank_state_t next_st;

  // masked writes, port b applied last so it wins on overlap
  always_comb
  begin
    next_st = st;
    if (power_on)
    begin
      next_st.mem[a_word] = (st.mem[a_word] & ~a_mask) | (a_data & a_mask);
      next_st.mem[b_word] = (next_st.mem[b_word] & ~b_mask)
                          | (b_data & b_mask);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst && power_on)
      st <= '0;
    else
      st <= next_st;
  end

  // old contents, zero while gated
  // no access when gated
  assign a_q  = power_on ? st.mem[a_word]  : '0;
  assign b_q  = power_on ? st.mem[b_word]  : '0;
  assign rb_q = power_on ? st.mem[rb_word] : '0;

endmodule : dpbr_bank

// file: rtl/dpbr_block_ram.sv
`timescale 1ns/1ns
// How it works
// - output register has its own enable
// - read and write widths set per port
// - mixed widths: new enabled bytes, old rest
// - simple mode doubles width to 72
// - simple mode: a reads, b writes, concurrently
// - same-location read/write is a collision
// - simple mode lacks hold-on-write behaviour
// - readback port works in every mode
// - two 32K x 1 banks form 64K x 1
// - enable count follows mode: 4 or 8
// - each enable gates byte plus parity
// - no byte enables in ecc mode
// - read-first shows whole old word
// - write-through merges new and old bytes
// - ecc corrects single, flags single/double
// - sync set/reset loads register or latch
// - unused bank gated, unreadable, uninitialised
// - output register adds one cycle
// - read-first shows old data while writing
// - disabled port neither writes nor changes, except on set/reset
module dpbr_block_ram #(
  parameter logic [71:0] SRVAL_A = dpbr_pkg::SRVAL_RST,
  parameter logic [71:0] SRVAL_B = dpbr_pkg::SRVAL_RST
) (
  input  wire logic                               mclk,
  input  wire logic                               sys_rst,
  input  wire dpbr_pkg::dpbr_mode_t               ram_mode,
  input  wire dpbr_pkg::dpbr_wmode_t              write_mode_a,
  input  wire dpbr_pkg::dpbr_wmode_t              write_mode_b,
  input  wire logic [dpbr_pkg::WCODE_W-1:0]       rd_width_a,
  input  wire logic [dpbr_pkg::WCODE_W-1:0]       wr_width_a,
  input  wire logic [dpbr_pkg::WCODE_W-1:0]       rd_width_b,
  input  wire logic [dpbr_pkg::WCODE_W-1:0]       wr_width_b,
  input  wire logic                               out_reg_a,
  input  wire logic                               out_reg_b,
  input  wire logic                               ecc_enable,
  input  wire logic                               ecc_raw_write,
  input  wire logic                               read_port_enable,
  input  wire logic [dpbr_pkg::ADDR_W-1:0]        read_location,
  input  wire logic [dpbr_pkg::DATA_W-1:0]        write_data_in_a,
  input  wire logic [dpbr_pkg::PAR_W-1:0]         write_parity_in_a,
  input  wire logic [dpbr_pkg::PAR_W-1:0]         byte_write_enable_a,
  input  wire logic                               output_pipe_clock_enable_a,
  input  wire logic                               output_sync_set_reset_a,
  input  wire logic                               write_port_enable,
  input  wire logic [dpbr_pkg::ADDR_W-1:0]        write_location,
  input  wire logic [dpbr_pkg::DATA_W-1:0]        write_data_in_b,
  input  wire logic [dpbr_pkg::PAR_W-1:0]         write_parity_in_b,
  input  wire logic [dpbr_pkg::PAR_W-1:0]         byte_write_enable_b,
  input  wire logic                               output_pipe_clock_enable_b,
  input  wire logic                               output_sync_set_reset_b,
  input  wire logic                               readback_request,
  input  wire logic                               readback_bank,
  input  wire logic [dpbr_pkg::WORD_AW-1:0]       readback_word,
  output logic      [dpbr_pkg::DATA_W-1:0]        read_data_out_a,
  output logic      [dpbr_pkg::PAR_W-1:0]         read_parity_out_a,
  output logic      [dpbr_pkg::DATA_W-1:0]        read_data_out_b,
  output logic      [dpbr_pkg::PAR_W-1:0]         read_parity_out_b,
  output logic                                    single_error_flag,
  output logic                                    double_error_flag,
  output logic      [dpbr_pkg::CODE_W-1:0]        code_encoder_output,
  output logic      [dpbr_pkg::WORD_W-1:0]        readback_data,
  output logic                                    readback_valid
);
  import dpbr_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] latch_a;
    logic [WORD_W-1:0] out_a;
    logic [WORD_W-1:0] latch_b;
    logic [WORD_W-1:0] out_b;
    logic              lat_sbe;
    logic              lat_dbe;
    logic              out_sbe;
    logic              out_dbe;
    logic [CODE_W-1:0] enc;
    logic [WORD_W-1:0] rb_data;
    logic              rb_valid;
  } dpbr_state_t;

  dpbr_state_t st;
  dpbr_state_t next_st;

  logic                 simple;
  logic                 casc;
  logic                 ecc_on;
  logic [WCODE_W-1:0]   rwa;
  logic [WCODE_W-1:0]   wwa;
  logic [WCODE_W-1:0]   rwb;
  logic [WCODE_W-1:0]   wwb;
  logic [PAR_W-1:0]     bea;
  logic [PAR_W-1:0]     beb;
  logic [2*WORD_W-1:0]  pla;
  logic [2*WORD_W-1:0]  plb;
  logic [WORD_W-1:0]    mask_a;
  logic [WORD_W-1:0]    data_a;
  logic [WORD_W-1:0]    mask_b;
  logic [WORD_W-1:0]    data_b;
  logic                 wr_a;
  logic                 wr_b;
  logic                 sel_a;
  logic                 sel_b;
  logic                 same;
  logic [WORD_AW-1:0]   word_a;
  logic [WORD_AW-1:0]   word_b;
  logic [WORD_W-1:0]    m0_a;
  logic [WORD_W-1:0]    m1_a;
  logic [WORD_W-1:0]    m0_b;
  logic [WORD_W-1:0]    m1_b;
  logic [WORD_W-1:0]    old_a;
  logic [WORD_W-1:0]    old_b;
  logic [WORD_W-1:0]    new_a;
  logic [WORD_W-1:0]    new_b;
  logic [WORD_W-1:0]    view_a;
  logic [WORD_W+1:0]    dec;
  logic [WORD_W-1:0]    enc_word;
  logic [WORD_W-1:0]    q0_a;
  logic [WORD_W-1:0]    q0_b;
  logic [WORD_W-1:0]    q1_a;
  logic [WORD_W-1:0]    q1_b;
  logic [WORD_W-1:0]    rb0;
  logic [WORD_W-1:0]    rb1;

  // width allowed in the current mode
  function automatic logic [WCODE_W-1:0] dpbr_eff_w(
    input dpbr_mode_t         m,
    input logic [WCODE_W-1:0] w
  );
    if (m == MODE_CASCADE)
      return W_X1;
    if (m != MODE_SIMPLE && w >= W_X72)
      return W_X36;
    if (w > W_X72)
      return W_X72;
    return w;
  endfunction : dpbr_eff_w

  // lanes of nine bits per width, zero for x1
  function automatic int dpbr_lanes(input logic [WCODE_W-1:0] w);
    unique case (w)
      W_X9:    return 1;
      W_X18:   return 2;
      W_X36:   return 4;
      W_X72:   return 8;
      default: return 0;
    endcase
  endfunction : dpbr_lanes

  // steer port data into a word: {mask, data}
  function automatic logic [2*WORD_W-1:0] dpbr_place(
    input logic [WCODE_W-1:0] w,
    input logic [14:0]        ba,
    input logic [DATA_W-1:0]  d,
    input logic [PAR_W-1:0]   p,
    input logic [PAR_W-1:0]   be
  );
    logic [WORD_W-1:0] m;
    logic [WORD_W-1:0] v;
    int                n;
    int                lane;
    m = '0;
    v = '0;
    n = dpbr_lanes(w);
    lane = 0;
    if (n == 0)
    begin
      m[LANE_W*int'(ba[5:3]) + int'(ba[2:0])] = be[0];
      v[LANE_W*int'(ba[5:3]) + int'(ba[2:0])] = d[0];
    end
    else
      for (int i = 0; i < LANES; i++)
        if (i < n)
        begin
          lane = (int'(ba[5:3]) & ~(n - 1)) + i;
          m[LANE_W*lane +: LANE_W] = {LANE_W{be[i]}};
          v[LANE_W*lane +: LANE_W] = {p[i], d[BYTE_W*i +: BYTE_W]};
        end
    return {m, v};
  endfunction : dpbr_place

  // pull a port-width value out of a word: {parity, data}
  function automatic logic [WORD_W-1:0] dpbr_pick(
    input logic [WCODE_W-1:0] w,
    input logic [14:0]        ba,
    input logic [WORD_W-1:0]  wd
  );
    logic [WORD_W-1:0] r;
    int                n;
    int                lane;
    r = '0;
    n = dpbr_lanes(w);
    lane = 0;
    if (n == 0)
      r[0] = wd[LANE_W*int'(ba[5:3]) + int'(ba[2:0])];
    else
      for (int i = 0; i < LANES; i++)
        if (i < n)
        begin
          lane = (int'(ba[5:3]) & ~(n - 1)) + i;
          r[BYTE_W*i +: BYTE_W] = wd[LANE_W*lane +: BYTE_W];
          r[DATA_W + i] = wd[LANE_W*lane + BYTE_W];
        end
    return r;
  endfunction : dpbr_pick

  // hamming code with overall parity at bit 0
  function automatic logic [WORD_W-1:0] dpbr_ecc_encode(
    input logic [DATA_W-1:0] d
  );
    logic [WORD_W-1:0] c;
    logic [6:0]        s;
    int                j;
    c = '0;
    s = '0;
    j = 0;
    for (int pos = 1; pos < WORD_W; pos++)
      if ((pos & (pos - 1)) != 0)
      begin
        c[pos] = d[j];
        j++;
      end
    for (int pos = 1; pos < WORD_W; pos++)
      if (c[pos])
        s = s ^ 7'(pos);
    for (int b = 0; b < 7; b++)
      c[1 << b] = s[b];
    c[0] = ^c;
    return c;
  endfunction : dpbr_ecc_encode

  // decode: {single, double, check bits, data}
  function automatic logic [WORD_W+1:0] dpbr_ecc_decode(
    input logic [WORD_W-1:0] cw
  );
    logic [WORD_W-1:0] c;
    logic [DATA_W-1:0] d;
    logic [6:0]        s;
    logic              all;
    logic              sbe;
    logic              dbe;
    int                j;
    c = cw;
    d = '0;
    s = '0;
    j = 0;
    all = ^cw;
    for (int pos = 1; pos < WORD_W; pos++)
      if (cw[pos])
        s = s ^ 7'(pos);
    sbe = all && (int'(s) < WORD_W);
    dbe = (s != '0 && !all) || (all && int'(s) >= WORD_W);
    if (sbe && s != '0)
      c[s] = ~c[s];
    for (int pos = 1; pos < WORD_W; pos++)
      if ((pos & (pos - 1)) != 0)
      begin
        d[j] = c[pos];
        j++;
      end
    return {sbe, dbe, c[64], c[32], c[16], c[8], c[4], c[2], c[1], c[0], d};
  endfunction : dpbr_ecc_decode

  // datapath and output stages
  always_comb
  begin
    next_st = st;
    simple = (ram_mode == MODE_SIMPLE);
    casc = (ram_mode == MODE_CASCADE);
    ecc_on = simple && ecc_enable;
    rwa = dpbr_eff_w(ram_mode, rd_width_a);
    wwa = dpbr_eff_w(ram_mode, wr_width_a);
    rwb = dpbr_eff_w(ram_mode, rd_width_b);
    wwb = dpbr_eff_w(ram_mode, wr_width_b);
    bea = byte_write_enable_a & FULL_BE;
    beb = simple ? byte_write_enable_b : (byte_write_enable_b & FULL_BE);
    if (ecc_on)
      beb = ALL_BE;
    pla = dpbr_place(wwa, read_location[14:0], write_data_in_a,
                     write_parity_in_a, bea);
    plb = dpbr_place(wwb, write_location[14:0], write_data_in_b,
                     write_parity_in_b, beb);
    mask_a = pla[2*WORD_W-1:WORD_W];
    data_a = pla[WORD_W-1:0];
    mask_b = plb[2*WORD_W-1:WORD_W];
    data_b = plb[WORD_W-1:0];
    enc_word = dpbr_ecc_encode(write_data_in_b);
    if (ecc_on && !ecc_raw_write)
      data_b = enc_word;
    // port a never writes in simple mode
    wr_a = !simple && read_port_enable && (mask_a != '0);
    wr_b = write_port_enable && (mask_b != '0);
    sel_a = casc && read_location[ADDR_W-1];
    sel_b = casc && write_location[ADDR_W-1];
    word_a = read_location[14:6];
    word_b = write_location[14:6];
    same = (word_a == word_b) && (sel_a == sel_b);
    m0_a = (wr_a && !sel_a) ? mask_a : '0;
    m1_a = (wr_a && sel_a) ? mask_a : '0;
    m0_b = (wr_b && !sel_b) ? mask_b : '0;
    m1_b = (wr_b && sel_b) ? mask_b : '0;
    old_a = sel_a ? q1_a : q0_a;
    old_b = sel_b ? q1_b : q0_b;
    new_a = (old_a & ~mask_a) | (data_a & mask_a);
    new_b = (old_b & ~mask_b) | (data_b & mask_b);
    // collision: write-through reader sees the write
    view_a = old_a;
    if (simple && same && wr_b && write_mode_a != WM_READ_FIRST)
      view_a = (old_a & ~mask_b) | (data_b & mask_b);
    dec = dpbr_ecc_decode(view_a);

    // port a latch stage
    // set/reset of the latch
    if (output_sync_set_reset_a && !out_reg_a)
    begin
      next_st.latch_a = SRVAL_A;
      next_st.lat_sbe = 1'b0;
      next_st.lat_dbe = 1'b0;
    end
    else if (read_port_enable)
    begin
      next_st.lat_sbe = 1'b0;
      next_st.lat_dbe = 1'b0;
      if (simple && ecc_on)
        {next_st.lat_sbe, next_st.lat_dbe, next_st.latch_a} = dec;
      else if (simple)
        // simple mode reads old or merged word only
        next_st.latch_a = dpbr_pick(rwa, read_location[14:0], view_a);
      else if (!wr_a)
        next_st.latch_a = dpbr_pick(rwa, read_location[14:0], old_a);
      else
        unique case (write_mode_a)
          WM_READ_FIRST:
            next_st.latch_a = dpbr_pick(rwa, read_location[14:0], old_a);
          WM_WRITE_FIRST:
            next_st.latch_a = dpbr_pick(rwa, read_location[14:0], new_a);
          WM_NO_CHANGE:
            next_st.latch_a = st.latch_a;
          default:
            next_st.latch_a = st.latch_a;
        endcase
    end

    // port a output stage
    // register adds a cycle
    if (!out_reg_a)
    begin
      next_st.out_a = next_st.latch_a;
      next_st.out_sbe = next_st.lat_sbe;
      next_st.out_dbe = next_st.lat_dbe;
    end
    else if (output_sync_set_reset_a)
    begin
      next_st.out_a = SRVAL_A;
      next_st.out_sbe = 1'b0;
      next_st.out_dbe = 1'b0;
    end
    else if (output_pipe_clock_enable_a)
    begin
      next_st.out_a = st.latch_a;
      next_st.out_sbe = st.lat_sbe;
      next_st.out_dbe = st.lat_dbe;
    end

    // port b latch stage, idle as reader in simple mode
    if (output_sync_set_reset_b && !out_reg_b)
      next_st.latch_b = SRVAL_B;
    else if (write_port_enable && !simple)
    begin
      if (!wr_b)
        next_st.latch_b = dpbr_pick(rwb, write_location[14:0], old_b);
      else
        unique case (write_mode_b)
          WM_READ_FIRST:
            next_st.latch_b = dpbr_pick(rwb, write_location[14:0], old_b);
          WM_WRITE_FIRST:
            next_st.latch_b = dpbr_pick(rwb, write_location[14:0], new_b);
          WM_NO_CHANGE:
            next_st.latch_b = st.latch_b;
          default:
            next_st.latch_b = st.latch_b;
        endcase
    end

    // port b output stage
    if (!out_reg_b)
      next_st.out_b = next_st.latch_b;
    else if (output_sync_set_reset_b)
      next_st.out_b = SRVAL_B;
    else if (output_pipe_clock_enable_b)
      next_st.out_b = st.latch_b;

    // encoder check bits of each ecc write
    if (ecc_on && wr_b)
      next_st.enc = {enc_word[64], enc_word[32], enc_word[16], enc_word[8],
                     enc_word[4], enc_word[2], enc_word[1], enc_word[0]};

    next_st.rb_valid = readback_request;
    if (readback_request)
      next_st.rb_data = readback_bank ? rb1 : rb0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  dpbr_bank #(
    .DEPTH (MEM_WORDS),
    .WIDTH (WORD_W)
  ) u_bank0 (
    .clk      (mclk),
    .rst      (sys_rst),
    .power_on (1'b1),
    .a_word   (word_a),
    .a_mask   (m0_a),
    .a_data   (data_a),
    .b_word   (word_b),
    .b_mask   (m0_b),
    .b_data   (data_b),
    .rb_word  (readback_word),
    .a_q      (q0_a),
    .b_q      (q0_b),
    .rb_q     (rb0)
  );

  // upper bank powered only in cascade
  dpbr_bank #(
    .DEPTH (MEM_WORDS),
    .WIDTH (WORD_W)
  ) u_bank1 (
    .clk      (mclk),
    .rst      (sys_rst),
    .power_on (casc),
    .a_word   (word_a),
    .a_mask   (m1_a),
    .a_data   (data_a),
    .b_word   (word_b),
    .b_mask   (m1_b),
    .b_data   (data_b),
    .rb_word  (readback_word),
    .a_q      (q1_a),
    .b_q      (q1_b),
    .rb_q     (rb1)
  );

  // outputs straight from the state flops
  assign read_data_out_a     = st.out_a[DATA_W-1:0];
  assign read_parity_out_a   = st.out_a[WORD_W-1:DATA_W];
  assign read_data_out_b     = st.out_b[DATA_W-1:0];
  assign read_parity_out_b   = st.out_b[WORD_W-1:DATA_W];
  assign single_error_flag   = st.out_sbe;
  assign double_error_flag   = st.out_dbe;
  assign code_encoder_output = st.enc;
  assign readback_data       = st.rb_data;
  assign readback_valid      = st.rb_valid;

endmodule : dpbr_block_ram

// file: verification/dpbr_block_ram_assertions.sv
`timescale 1ns/1ns
module dpbr_block_ram_assertions
  import dpbr_pkg::*;
#(
  parameter logic [71:0] SRVAL_A = SRVAL_RST
) (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire dpbr_mode_t  ram_mode,
  input wire dpbr_wmode_t write_mode_b,
  input wire logic [2:0]  rd_width_b,
  input wire logic        out_reg_a,
  input wire logic        out_reg_b,
  input wire logic        ecc_enable,
  input wire logic        read_port_enable,
  input wire logic        output_pipe_clock_enable_a,
  input wire logic        output_sync_set_reset_a,
  input wire logic        output_sync_set_reset_b,
  input wire logic        write_port_enable,
  input wire logic [63:0] write_data_in_b,
  input wire logic [7:0]  byte_write_enable_b,
  input wire logic        readback_request,
  input wire logic        readback_valid,
  input wire logic [63:0] read_data_out_a,
  input wire logic [7:0]  read_parity_out_a,
  input wire logic [63:0] read_data_out_b,
  input wire logic        single_error_flag,
  input wire logic        double_error_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // set/reset request and its loaded value
  sequence s_sr_req;
    output_sync_set_reset_a;
  endsequence
  sequence s_sr_val;
    {read_parity_out_a, read_data_out_a} == SRVAL_A;
  endsequence

  a_rb_pulse: assert property (readback_request |=> readback_valid)
    else $error("readback answer missing");
  a_sr_load: assert property (s_sr_req |=> s_sr_val)
    else $error("set/reset value not loaded");
  a_hold_dis: assert property (!read_port_enable && !out_reg_a
    && !output_sync_set_reset_a |=> out_reg_a || $stable(read_data_out_a))
    else $error("disabled port output moved");
  a_pipe_hold: assert property (out_reg_a && !output_pipe_clock_enable_a
    && !output_sync_set_reset_a |=> out_reg_a
    && $stable({read_parity_out_a, read_data_out_a}))
    else $error("pipeline register moved");
  a_b_quiet: assert property (ram_mode == MODE_SIMPLE
    |=> $stable(read_data_out_b))
    else $error("write port output moved");
  a_flag_off: assert property (!ecc_enable [*2]
    |-> !single_error_flag && !double_error_flag)
    else $error("error flag without ecc");
  a_casc_bit: assert property (ram_mode == MODE_CASCADE
    |=> read_data_out_a[63:1] == 63'h0 && read_parity_out_a == 8'h00)
    else $error("cascade output wider than one bit");
  a_wf_b: assert property (ram_mode == MODE_FULL
    && write_mode_b == WM_WRITE_FIRST && rd_width_b == W_X36 && !out_reg_b
    && write_port_enable && byte_write_enable_b[3:0] == 4'hf
    && !output_sync_set_reset_b
    |=> read_data_out_b[31:0] == $past(write_data_in_b[31:0]))
    else $error("write-through data missing");
endmodule : dpbr_block_ram_assertions

bind dpbr_block_ram dpbr_block_ram_assertions #(.SRVAL_A(SRVAL_A)) u_chk (
  .mclk, .sys_rst, .ram_mode, .write_mode_b, .rd_width_b, .out_reg_a,
  .out_reg_b, .ecc_enable, .read_port_enable, .output_pipe_clock_enable_a,
  .output_sync_set_reset_a, .output_sync_set_reset_b, .write_port_enable,
  .write_data_in_b, .byte_write_enable_b, .readback_request,
  .readback_valid, .read_data_out_a, .read_parity_out_a, .read_data_out_b,
  .single_error_flag, .double_error_flag
);

// file: verification/dpbr_user_logic.sv
`timescale 1ns/1ns
module dpbr_user_logic (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [15:0] loc,
  input  wire logic [71:0] wd,
  input  wire logic [7:0]  be,
  output logic             write_port_enable,
  output logic      [15:0] write_location,
  output logic      [63:0] write_data_in_b,
  output logic      [7:0]  write_parity_in_b,
  output logic      [7:0]  byte_write_enable_b
);
  // idle lines start defined
  initial
  begin
    write_port_enable = 1'b0;
    write_location = 16'h0;
    {write_parity_in_b, write_data_in_b} = 72'h0;
    byte_write_enable_b = 8'h00;
  end

  // one enabled cycle per request; idle location and data toggle, byte enables stay zero
  always @(posedge mclk)
  begin
    write_port_enable <= go;
    write_location <= go ? loc : ~write_location;
    {write_parity_in_b, write_data_in_b} <= go ? wd
      : ~{write_parity_in_b, write_data_in_b};
    byte_write_enable_b <= go ? be : 8'h00;
  end
endmodule : dpbr_user_logic

// file: verification/test_dpbr_block_ram.sv
`timescale 1ns/1ns
module test_dpbr_block_ram;
  import dpbr_pkg::*;
  typedef struct {int d; int s; logic [71:0] v;} dpbr_exp_t;
  dpbr_exp_t q[$];
  dpbr_exp_t x;
  int cyc = 0, n_errors = 0, n_checks = 0;
  logic mclk = 1'b0, sys_rst = 1'b1, go = 1'b0;
  logic [15:0] loc = 16'h0;
  logic [71:0] wd = 72'h0, w1, w2, w3, e;
  logic [7:0] wbe = 8'h00;
  dpbr_mode_t ram_mode = MODE_SIMPLE;
  dpbr_wmode_t write_mode_a = WM_WRITE_FIRST;
  dpbr_wmode_t write_mode_b = WM_WRITE_FIRST;
  logic [2:0] rd_width_a = W_X72, wr_width_a = W_X72;
  logic [2:0] rd_width_b = W_X72, wr_width_b = W_X72;
  logic out_reg_a = 1'b0, read_port_enable = 1'b0;
  logic output_pipe_clock_enable_a = 1'b1, output_sync_set_reset_a = 1'b0;
  logic [15:0] read_location = 16'h0;
  logic [63:0] write_data_in_a = 64'h0;
  logic [7:0] write_parity_in_a = 8'h0, byte_write_enable_a = 8'h0;
  logic readback_request = 1'b0, readback_bank = 1'b0;
  logic [8:0] readback_word = 9'h0;
  logic write_port_enable, single_error_flag, double_error_flag, readback_valid;
  logic [15:0] write_location;
  logic [63:0] write_data_in_b, read_data_out_a, read_data_out_b;
  logic [7:0] write_parity_in_b, byte_write_enable_b;
  logic [7:0] read_parity_out_a, read_parity_out_b;
  logic [71:0] readback_data;

  always #4 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  dpbr_user_logic u_dpbr_user_logic (.mclk, .go, .loc, .wd, .be(wbe),
    .write_port_enable, .write_location, .write_data_in_b,
    .write_parity_in_b, .byte_write_enable_b);

  dpbr_block_ram u_dpbr_block_ram (.mclk, .sys_rst, .ram_mode,
    .write_mode_a, .write_mode_b, .rd_width_a, .wr_width_a, .rd_width_b,
    .wr_width_b, .out_reg_a, .out_reg_b(1'b0), .ecc_enable(1'b0),
    .ecc_raw_write(1'b0), .read_port_enable, .read_location,
    .write_data_in_a, .write_parity_in_a, .byte_write_enable_a,
    .output_pipe_clock_enable_a, .output_sync_set_reset_a,
    .write_port_enable, .write_location, .write_data_in_b,
    .write_parity_in_b, .byte_write_enable_b,
    .output_pipe_clock_enable_b(1'b1), .output_sync_set_reset_b(1'b0),
    .readback_request, .readback_bank, .readback_word, .read_data_out_a,
    .read_parity_out_a, .read_data_out_b, .read_parity_out_b,
    .single_error_flag, .double_error_flag, .code_encoder_output(),
    .readback_data, .readback_valid);

  // lane merge on {parity, data} layout
  function automatic logic [71:0] mg(logic [71:0] o, n, logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
      begin
        o[8*i+:8] = n[8*i+:8];
        o[64+i] = n[64+i];
      end
    end
    return o;
  endfunction : mg

  // stored word layout seen by readback
  function automatic logic [71:0] pk(logic [71:0] v);
    for (int i = 0; i < 8; i++)
    begin
      pk[9*i+:9] = {v[64+i], v[8*i+:8]};
    end
  endfunction : pk

  task automatic chk(logic [71:0] g, logic [71:0] w);
    n_checks++;
    if (g !== w)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, w);
    end
  endtask : chk

  task automatic push(int lat, int s, logic [71:0] v);
    if (lat > 0)
    begin
      q.push_back('{cyc + lat, s, v});
    end
  endtask : push

  task automatic rst(dpbr_mode_t m);
    @(posedge mclk);
    sys_rst <= 1'b1;
    ram_mode <= m;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : rst

  // port a access, a write outside simple mode when b & FULL_BE enables a lane of the write width (only b[0] at x1 and x9)
  task automatic ra(logic [15:0] a, logic [7:0] b, logic [71:0] d,
                    logic [71:0] v, int lat);
    @(posedge mclk);
    read_port_enable <= 1'b1;
    read_location <= a;
    byte_write_enable_a <= b;
    {write_parity_in_a, write_data_in_a} <= d;
    push(lat, 0, v);
    @(posedge mclk);
    read_port_enable <= 1'b0;
    byte_write_enable_a <= 8'h00;
  endtask : ra

  // port b write through the user model
  task automatic wb(logic [15:0] a, logic [71:0] d, logic [7:0] b,
                    int lat, logic [71:0] v);
    @(posedge mclk);
    go <= 1'b1;
    loc <= a;
    wd <= d;
    wbe <= b;
    push(lat, 1, v);
    @(posedge mclk);
    go <= 1'b0;
  endtask : wb

  task automatic rb(logic k, logic [8:0] w, logic [71:0] v);
    @(posedge mclk);
    readback_request <= 1'b1;
    readback_bank <= k;
    readback_word <= w;
    push(2, 2, v);
    @(posedge mclk);
    readback_request <= 1'b0;
  endtask : rb

  // compare each result as its note falls due
  always @(negedge mclk)
  begin
    while (q.size() > 0 && q[0].d == cyc)
    begin
      x = q.pop_front();
      chk(x.s == 0 ? {read_parity_out_a, read_data_out_a} : x.s == 1 ?
        {read_parity_out_b, read_data_out_b} : readback_data, x.v);
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0 && q.size() == 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // watchdog
  initial
  begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    test_done();
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h512c));
    w1 = {8'($urandom), $urandom, $urandom};
    w2 = {8'($urandom), $urandom, $urandom};
    w3 = {8'($urandom), $urandom, $urandom};
    rst(MODE_SIMPLE);
    wb(16'h0040, w1, 8'hff, 0, 0);
    ra(16'h0040, 8'h00, w3, w1, 2);
    e = mg(w1, w2, 8'h0f);
    wb(16'h0040, w2, 8'h0f, 0, 0);
    ra(16'h0040, 8'hff, w3, e, 2);
    rb(1'b0, 9'h001, pk(e));
    rb(1'b1, 9'h001, 72'h0);
    out_reg_a <= 1'b1;
    ra(16'h0040, 8'h00, 0, e, 3);
    repeat (2) @(posedge mclk);
    output_pipe_clock_enable_a <= 1'b0;
    ra(16'h0000, 8'h00, 0, e, 3);
    @(posedge mclk);
    output_pipe_clock_enable_a <= 1'b1;
    output_sync_set_reset_a <= 1'b1;
    @(posedge mclk);
    output_sync_set_reset_a <= 1'b0;
    out_reg_a <= 1'b0;
    {rd_width_a, wr_width_a, rd_width_b, wr_width_b} <= {4{W_X36}};
    write_mode_a <= WM_READ_FIRST;
    rst(MODE_FULL);
    e = mg(72'h0, w1, 8'h0f);
    wb(16'h0000, w1, 8'hff, 3, e);
    e = mg(e, w2, 8'h03);
    wb(16'h0000, w2, 8'h03, 3, e);
    ra(16'h0000, 8'h01, w3, e, 2);
    ra(16'h0000, 8'h00, 0, mg(e, w3, 8'h01), 2);
    rst(MODE_CASCADE);
    wb(16'h8005, 72'h1, 8'hff, 3, 72'h1);
    ra(16'h8005, 8'h00, 0, 72'h1, 2);
    ra(16'h0005, 8'h00, 0, 72'h0, 2);
    repeat (4) @(posedge mclk);
    test_done();
  end
endmodule : test_dpbr_block_ram
